// >>> dtpg_gen.sv
// Purpose: test pattern generation and output ordering for the serial data channels
// Assumes: word clock arrives as a slow pin, sampled here; markers are on the system clock
// Notes: one output word per rising word clock edge; registers over Avalon-MM
//
// Behaviour
// - 8-bit mode drops two low generated bits
// - sync channel never carries tests
// - no select: image data; fixed: seed word
// - counting mode starts at the seed word
// - random select wins, seeded by seed word
// - framed: tests inside markers, training outside
// - framed fixed and counting modes get real checks
// - unframed: test words always, never training
// - sync channel keeps regular timing codes
// - test words injected per channel directly
// - each channel holds its own seed word
// - count up, wrap back to seed word
// - framed counting reloads seed at line start
// - each channel random generator own seed
// - random mode: check slot gets random word
// - colour subsampling reads pairs 0,1,4,5...124,125
// - subsampled order equal for odd kernels
// - binning order equals subsampled order
// - training word programmable, default 0x3A6
// - check covers valid words, reseeded per line
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
module dtpg_gen (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [dtpg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // output word clock pin
  input wire logic word_clk,
  // sequencer side
  input wire dtpg_pkg::dtpg_mark_t mark,
  input wire logic [dtpg_pkg::WORD_W-1:0] sync_code,
  input wire dtpg_pkg::dtpg_words_t adc_words,
  // serial channel words
  output dtpg_pkg::dtpg_words_t data_words,
  output logic [dtpg_pkg::WORD_W-1:0] sync_word,
  output logic word_strobe,
  // pixel order for the column readout
  output dtpg_pkg::dtpg_pix_t pixel_first,
  output dtpg_pkg::dtpg_pix_t pixel_second
);

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic [2:0] wclk;
    logic ack;
    logic [31:0] rdata;
    dtpg_pkg::dtpg_cfg_t cfg;
    dtpg_pkg::dtpg_cfg_t act;
    logic [9:0] train;
    dtpg_pkg::dtpg_words_t seed;
    dtpg_pkg::dtpg_words_t cnt;
    dtpg_pkg::dtpg_words_t lfsr;
    dtpg_pkg::dtpg_words_t crc;
    dtpg_pkg::dtpg_words_t dout;
    logic [9:0] sync;
    logic strobe;
    logic in_line;
    dtpg_pkg::dtpg_pix_t pix1;
    dtpg_pkg::dtpg_pix_t pix2;
  } dtpg_state_t;

  dtpg_state_t st;
  dtpg_state_t next_st;

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [9:0] crc_word(input logic [9:0] c, input logic [9:0] d, input logic eight);
    logic [9:0] r;
    logic fb;
    r = c;
    for (int i = 9; i >= 0; i--)
    begin
      if (eight)
      begin
        if (i < 8)
        begin
          fb = r[7] ^ d[i];
          r = {2'h0, r[6:0], 1'b0} ^ (fb ? dtpg_pkg::CRC8_POLY : 10'h000);
        end
      end
      else
      begin
        fb = r[9] ^ d[i];
        r = {r[8:0], 1'b0} ^ (fb ? dtpg_pkg::CRC10_POLY : 10'h000);
      end
    end
    return r;
  endfunction

  // x^10 + x^7 + 1, one full word of shifts per output word
  function automatic logic [9:0] prbs_word(input logic [9:0] l);
    logic [9:0] r;
    r = l;
    for (int i = 0; i < 10; i++)
    begin
      r = {r[8:0], r[9] ^ r[6]};
    end
    return r;
  endfunction

  function automatic logic [9:0] send_form(input logic [9:0] w, input logic eight);
    logic [9:0] r;
    r = eight ? {2'h0, w[9:2]} : w;
    return r;
  endfunction

  function automatic logic [9:0] crc_init(input dtpg_pkg::dtpg_cfg_t c);
    logic [9:0] r;
    if (!c.crc_seed)
    begin
      r = 10'h000;
    end
    else
    begin
      r = c.eight_bit ? dtpg_pkg::CRC_ONES8 : dtpg_pkg::CRC_ONES10;
    end
    return r;
  endfunction

  // ***********************************************
  // register decode
  // ***********************************************
  logic hit_ctrl;
  logic hit_train;
  logic hit_status;
  logic hit_seed;
  logic bus_take;
  logic bus_commit;

  // seed window is word aligned; stray byte offsets read back zero
  assign hit_ctrl = (address == dtpg_pkg::REG_CTRL);
  assign hit_train = (address == dtpg_pkg::REG_TRAIN);
  assign hit_status = (address == dtpg_pkg::REG_STATUS);
  assign hit_seed = (address >= dtpg_pkg::REG_SEED_BASE) && (address <= dtpg_pkg::REG_SEED_LAST)
    && (address[1:0] == 2'h0);
  // one fixed wait state, so answer time never depends on the word clock
  assign bus_take = (read | write) & ~st.ack;
  assign bus_commit = write & st.ack;

  // ***********************************************
  // next state
  // ***********************************************
  logic tick;
  logic [9:0] gen;
  logic [9:0] sent;
  logic [9:0] ch_seed;
  logic [6:0] base2;
  logic [6:0] base4;
  logic test_on;
  logic line_go;
  dtpg_pkg::dtpg_cfg_t eff;
  int sel;

  assign tick = st.wclk[1] & ~st.wclk[2];
  assign waitrequest = bus_take;

  always_comb
  begin
    next_st = st;
    gen = 10'h000;
    sent = 10'h000;
    ch_seed = 10'h000;
    base2 = 7'h00;
    base4 = 7'h00;
    sel = 0;
    // wclk[0] feeds only wclk[1]
    next_st.wclk = {st.wclk[1:0], word_clk};
    next_st.strobe = tick;

    // bus: one wait cycle, answer on the second
    next_st.ack = bus_take;
    if (bus_take)
    begin
      next_st.rdata = 32'h0000_0000;
      if (hit_ctrl)
      begin
        next_st.rdata[8:0] = st.cfg;
      end
      else if (hit_train)
      begin
        next_st.rdata[9:0] = st.train;
      end
      else if (hit_status)
      begin
        next_st.rdata[8:0] = st.act;
        next_st.rdata[9] = st.in_line;
      end
      else if (hit_seed)
      begin
        sel = int'(address[6:2]);
        next_st.rdata[9:0] = st.seed[sel];
      end
    end
    if (bus_commit)
    begin
      if (hit_ctrl)
      begin
        next_st.cfg = writedata[8:0];
      end
      else if (hit_train)
      begin
        next_st.train = writedata[9:0];
      end
      else if (hit_seed)
      begin
        sel = int'(address[6:2]);
        next_st.seed[sel] = writedata[9:0];
      end
    end

    line_go = tick & mark.seq_enable & mark.line_start;
    eff = line_go ? st.cfg : st.act;
    test_on = eff.prbs_en | eff.testpattern_en;

    if (tick)
    begin
      next_st.act = eff;
      // sync channel passes timing codes, two low bits dropped in 8-bit mode
      next_st.sync = send_form(sync_code, eff.eight_bit);
      if (line_go)
      begin
        next_st.in_line = 1'b1;
      end
      else if (mark.crc_slot)
      begin
        next_st.in_line = 1'b0;
      end

      // words built per channel, final order
      for (int c = 0; c < dtpg_pkg::NUM_CH; c++)
      begin
        ch_seed = st.seed[c];
        if (line_go)
        begin
          next_st.cnt[c] = ch_seed;
          next_st.crc[c] = crc_init(eff);
        end
        // random generator seeded on mode entry
        if (line_go & st.cfg.prbs_en & ~st.act.prbs_en)
        begin
          next_st.lfsr[c] = ch_seed;
        end
        if (eff.prbs_en)
        begin
          gen = next_st.lfsr[c];
        end
        else if (eff.inc_testpattern)
        begin
          gen = next_st.cnt[c];
        end
        else
        begin
          gen = ch_seed;
        end

        if (test_on & ~eff.frame_testpattern)
        begin
          sent = gen;
        end
        else if (mark.seq_enable & mark.data_valid)
        begin
          // normal image data when no select
          sent = test_on ? gen : adc_words[c];
        end
        else if (mark.seq_enable & mark.crc_slot)
        begin
          // random mode: extra random word, else real check
          sent = eff.prbs_en ? gen : st.crc[c];
        end
        else
        begin
          sent = st.train;
        end

        // generate at full width, drop two low bits in 8-bit mode
        next_st.dout[c] = send_form(sent, eff.eight_bit);

        if (mark.seq_enable & mark.data_valid & ~line_go)
        begin
          next_st.crc[c] = crc_word(st.crc[c], next_st.dout[c], eff.eight_bit);
        end
        else if (mark.seq_enable & mark.data_valid)
        begin
          next_st.crc[c] = crc_word(crc_init(eff), next_st.dout[c], eff.eight_bit);
        end

        // generators advance once per test or check word sent, never on training words
        if (test_on & (~eff.frame_testpattern | (mark.seq_enable & (mark.data_valid | mark.crc_slot))))
        begin
          if (eff.prbs_en)
          begin
            next_st.lfsr[c] = prbs_word(next_st.lfsr[c]);
          end
          // wrap after all-ones back to seed
          else if (eff.inc_testpattern)
          begin
            next_st.cnt[c] = (next_st.cnt[c] == dtpg_pkg::WORD_MAX) ? ch_seed : next_st.cnt[c] + 10'h001;
          end
        end

        // pixel pair carried by this channel
        base2 = 7'(2 * c);
        base4 = 7'(4 * c);
        if (eff.mode == dtpg_pkg::MODE_FULL)
        begin
          next_st.pix1[c] = mark.kernel_odd ? dtpg_pkg::KERNEL_LAST - base2 : base2;
          next_st.pix2[c] = mark.kernel_odd ? dtpg_pkg::KERNEL_LAST - base2 - 7'h01 : base2 + 7'h01;
        end
        // subsampled and binned ignore kernel parity
        else
        begin
          next_st.pix1[c] = base4;
          // colour: pairs 4n, 4n+1 of 128-pixel kernel
          next_st.pix2[c] = eff.color ? base4 + 7'h01 : base4 + 7'h02;
        end
      end
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.train <= dtpg_pkg::TRAIN_RESET;
      st.seed <= {dtpg_pkg::NUM_CH{dtpg_pkg::SEED_RESET}};
      st.dout <= {dtpg_pkg::NUM_CH{dtpg_pkg::TRAIN_RESET}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // only data lanes carry generated words
  assign data_words = st.dout;
  assign sync_word = st.sync;
  assign word_strobe = st.strobe;
  assign readdata = st.rdata;
  assign pixel_first = st.pix1;
  assign pixel_second = st.pix2;

endmodule

// >>> dtpg_pkg.sv
// Purpose: shared constants and types of the data channel test pattern generator
// Assumes: 32 data channels of 10-bit words, Avalon-MM byte addresses
// Notes: channel words travel as packed arrays, one lane per channel
package dtpg_pkg;

  // ***********************************************
  // geometry
  // ***********************************************
  localparam int NUM_CH = 32;
  localparam int WORD_W = 10;
  localparam int PIX_W = 7;
  localparam int ADDR_W = 9;

  // ***********************************************
  // register map, byte addresses
  // ***********************************************
  localparam logic [8:0] REG_CTRL = 9'h000;
  localparam logic [8:0] REG_TRAIN = 9'h004;
  localparam logic [8:0] REG_STATUS = 9'h008;
  localparam logic [8:0] REG_SEED_BASE = 9'h080;
  localparam logic [8:0] REG_SEED_LAST = 9'h0FC;

  // ***********************************************
  // reset values and coding constants
  // ***********************************************
  localparam logic [9:0] TRAIN_RESET = 10'h3A6;
  localparam logic [9:0] SEED_RESET = 10'h001;
  localparam logic [9:0] WORD_MAX = 10'h3FF;
  localparam logic [9:0] CRC10_POLY = 10'h24F;
  localparam logic [9:0] CRC8_POLY = 10'h04D;
  localparam logic [9:0] CRC_ONES10 = 10'h3FF;
  localparam logic [9:0] CRC_ONES8 = 10'h0FF;
  localparam logic [6:0] KERNEL_LAST = 7'h3F;

  // readout modes
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_SUB = 2'h1;
  localparam logic [1:0] MODE_BIN = 2'h2;

  typedef logic [NUM_CH-1:0][WORD_W-1:0] dtpg_words_t;
  typedef logic [NUM_CH-1:0][PIX_W-1:0] dtpg_pix_t;

  // software configuration, bit 0 first from the bottom
  typedef struct packed {
    logic color;
    logic [1:0] mode;
    logic crc_seed;
    logic eight_bit;
    logic frame_testpattern;
    logic inc_testpattern;
    logic testpattern_en;
    logic prbs_en;
  } dtpg_cfg_t;

  // timing markers from the sequencer, levels held for one word
  typedef struct packed {
    logic seq_enable;
    logic line_start;
    logic data_valid;
    logic crc_slot;
    logic kernel_odd;
  } dtpg_mark_t;

endpackage

// >>> dtpg_gen_monitor.sv
// Purpose: port level checks of the test pattern generator
// Assumes: one clock domain, reset_n asynchronous active low
// Notes: bound to every dtpg_gen instance
module dtpg_gen_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // avalon-mm
  input wire logic [dtpg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // word link
  input wire logic word_clk,
  input wire dtpg_pkg::dtpg_mark_t mark,
  input wire logic [dtpg_pkg::WORD_W-1:0] sync_code,
  input wire dtpg_pkg::dtpg_words_t adc_words,
  input wire dtpg_pkg::dtpg_words_t data_words,
  input wire logic [dtpg_pkg::WORD_W-1:0] sync_word,
  input wire logic word_strobe,
  input wire dtpg_pkg::dtpg_pix_t pixel_first,
  input wire dtpg_pkg::dtpg_pix_t pixel_second
);
  // ***********************************************
  // properties
  // ***********************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_wait_first; $rose(read || write) |-> waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("waitrequest low in first bus cycle");
  property p_wait_one; $rose(read || write) |=> !waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_unmapped; read && !waitrequest && address == 9'h040 |-> readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_train_rd; read && !waitrequest && address == dtpg_pkg::REG_TRAIN |-> readdata[31:10] == 22'h0; endproperty
  a_train_rd: assert property (p_train_rd) else $error("training word wider than ten bits");
  property p_strobe; word_strobe |=> !word_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("word strobe longer than a cycle");
  property p_tick; $rose(word_strobe) |-> $past(word_clk, 2) || $past(word_clk, 3) || $past(word_clk, 4); endproperty
  a_tick: assert property (p_tick) else $error("word without word clock edge");
  property p_hold; !word_strobe |-> $stable(data_words) && $stable(sync_word) && $stable(pixel_first); endproperty
  a_hold: assert property (p_hold) else $error("channel words moved between ticks");
  property p_sync; word_strobe |-> sync_word == $past(sync_code) || sync_word == {2'h0, $past(sync_code[9:2])}; endproperty
  a_sync: assert property (p_sync) else $error("sync channel altered");
  property p_pix; word_strobe |-> pixel_first[31] inside {7'h01, 7'h3E, 7'h7C} && pixel_second[31] inside {7'h00, 7'h3F, 7'h7D, 7'h7E}; endproperty
  a_pix: assert property (p_pix) else $error("last channel pixel pair wrong");
  c_word: cover property (word_strobe);
  c_write: cover property (write && !waitrequest);
  c_train: cover property (read && !waitrequest && address == dtpg_pkg::REG_TRAIN);
endmodule
bind dtpg_gen dtpg_gen_monitor u_mon (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .word_clk(word_clk),
  .mark(mark), .sync_code(sync_code), .adc_words(adc_words), .data_words(data_words), .sync_word(sync_word),
  .word_strobe(word_strobe), .pixel_first(pixel_first), .pixel_second(pixel_second));

// >>> dtpg_rx_model.sv
// Purpose: receiver that captures the serial channel words
// Assumes: words stand in the strobe cycle
// Notes: lanes kept as sent, no regrouping
module dtpg_rx_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // channel words
  input wire logic word_strobe,
  input wire dtpg_pkg::dtpg_words_t data_words,
  // capture summary
  output logic [15:0] rx_count,
  output dtpg_pkg::dtpg_words_t rx_words
);
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_count <= 16'h0;
      rx_words <= '0;
    end
    else if (word_strobe)
    begin
      rx_count <= rx_count + 16'h1;
      rx_words <= data_words;
    end
  end
endmodule

// >>> dtpg_gen_tb_top.sv
// Purpose: self-checking bench of the test pattern generator
// Assumes: 20 MHz clock, 400 ns word clock of unrelated phase
// Notes: reset and register checks first, then table rows, then hand-written cases
module dtpg_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [8:0] ctrl; logic [4:0] ch; logic [39:0] e; logic [13:0] pix;} dtpg_row_t;
  logic clock = 0;
  logic reset_n = 0;
  logic [8:0] address = 9'h000;
  logic read = 0;
  logic write = 0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest;
  logic word_clk = 0;
  logic word_strobe;
  dtpg_pkg::dtpg_mark_t mark = 5'h00;
  logic [9:0] sync_code = 10'h2C5;
  logic [9:0] sync_word;
  dtpg_pkg::dtpg_words_t adc_words = {32{10'h155}};
  dtpg_pkg::dtpg_words_t data_words;
  dtpg_pkg::dtpg_pix_t pixel_first;
  dtpg_pkg::dtpg_pix_t pixel_second;
  logic [15:0] rx_count;
  int num_errors = 0;
  int n_tests = 0;
  // framed sequence: marks and the words they give
  logic [4:0] fm [6] = '{5'h1D, 5'h15, 5'h11, 5'h11, 5'h1D, 5'h15};
  logic [9:0] fe [6] = '{10'h3FD, 10'h3FE, 10'h2AA, 10'h2AA, 10'h3FD, 10'h3FE};
  dtpg_row_t rows [8] = '{
    '{9'h000, 5'h1D, {4{10'h155}}, {7'h01, 7'h00}}, '{9'h002, 5'h1D, {4{10'h3FD}}, {7'h01, 7'h00}},
    '{9'h002, 5'h00, {4{10'h3E0}}, {7'h01, 7'h00}},
    '{9'h006, 5'h1D, {10'h3FD, 10'h3FE, 10'h3FF, 10'h3FD}, {7'h01, 7'h00}},
    '{9'h012, 5'h1D, {4{10'h0FF}}, {7'h01, 7'h00}}, '{9'h042, 5'h1D, {4{10'h3FD}}, {7'h7C, 7'h7E}},
    '{9'h082, 5'h1D, {4{10'h3FD}}, {7'h7C, 7'h7E}}, '{9'h142, 5'h1D, {4{10'h3FD}}, {7'h7C, 7'h7D}}};

  dtpg_gen uut (.clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .word_clk(word_clk), .mark(mark),
    .sync_code(sync_code), .adc_words(adc_words), .data_words(data_words), .sync_word(sync_word),
    .word_strobe(word_strobe), .pixel_first(pixel_first), .pixel_second(pixel_second));
  dtpg_rx_model u_rx (.clock(clock), .reset_n(reset_n), .word_strobe(word_strobe), .data_words(data_words),
    .rx_count(rx_count), .rx_words());

  always #25 clock = ~clock;
  initial
  begin
    #13;
    forever #200 word_clk = ~word_clk;
  end

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got, input bit ne = 0);
    n_tests++;
    if (ne ? (got === exp || $isunknown(got)) : (got !== exp))
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // line check per the 10-bit polynomial, msb first
  function automatic logic [9:0] crc10(input logic [9:0] c, input logic [9:0] d);
    logic [9:0] r;
    r = c;
    for (int i = 9; i >= 0; i--)
      r = {r[8:0], 1'b0} ^ ((r[9] ^ d[i]) ? dtpg_pkg::CRC10_POLY : 10'h000);
    return r;
  endfunction

  // ten shifts of x^10 + x^7 + 1 per word
  function automatic logic [9:0] prbs10(input logic [9:0] l);
    logic [9:0] r;
    r = l;
    for (int i = 0; i < 10; i++)
      r = {r[8:0], r[9] ^ r[6]};
    return r;
  endfunction

  // request held until waitrequest is sampled low at a rising edge
  task automatic avm(input logic we, input logic [8:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= !we;
    write <= we;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (waitrequest !== 1'b0 && i < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic wait_word;
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clock);
      if (word_strobe === 1'b1)
        break;
    end
    if (i == 40)
    begin
      num_errors++;
      test_done();
    end
  endtask

  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    repeat (16) @(posedge clock);
    chk("reset word", 32'h3A6, 32'(data_words[31]));
    reset_n <= 1'b1;
    avm(1'b0, dtpg_pkg::REG_TRAIN, 32'h0);
    chk("train reg", 32'h3A6, rd);
    avm(1'b0, dtpg_pkg::REG_SEED_BASE, 32'h0);
    chk("seed reg", 32'h1, rd);
    avm(1'b0, 9'h040, 32'h0);
    chk("unmapped", 32'h0, rd);
    // nonzero, distinct seeds keep random lanes alive
    for (int c = 0; c < 32; c++)
      avm(1'b1, dtpg_pkg::REG_SEED_BASE + 9'(4 * c), 32'h3E0 + c);
    foreach (rows[r])
    begin
      avm(1'b1, dtpg_pkg::REG_CTRL, 32'(rows[r].ctrl));
      wait_word;
      mark <= 5'h1D;
      for (int k = 0; k < 4; k++)
      begin
        wait_word;
        mark <= 5'h15;
        chk("lane word", 32'(rows[r].e[39 - 10 * k -: 10]), 32'(data_words[rows[r].ch]));
      end
      chk("pixel pair", 32'(rows[r].pix), {18'h0, pixel_first[31], pixel_second[31]});
    end
    avm(1'b1, dtpg_pkg::REG_CTRL, 32'h0);
    wait_word;
    wait_word;
    chk("mid line", 32'h3FD, 32'(data_words[29]));
    avm(1'b1, dtpg_pkg::REG_TRAIN, 32'h2AA);
    avm(1'b1, dtpg_pkg::REG_CTRL, 32'h00E);
    wait_word;
    for (int k = 0; k < 6; k++)
    begin
      mark <= fm[k];
      wait_word;
      chk("framed", 32'(fe[k]), 32'(data_words[29]));
    end
    // training gap before the check slot must not enter the check
    mark <= 5'h11;
    wait_word;
    chk("train gap", 32'h2AA, 32'(data_words[29]));
    mark <= 5'h13;
    wait_word;
    chk("crc slot", 32'(crc10(crc10(10'h000, 10'h3FD), 10'h3FE)), 32'(data_words[29]));
    avm(1'b1, dtpg_pkg::REG_CTRL, 32'h009);
    wait_word;
    mark <= 5'h1D;
    wait_word;
    mark <= 5'h15;
    rd = 32'(data_words[29]);
    chk("prbs seed", 32'h3FD, rd);
    wait_word;
    chk("prbs step", rd, 32'(data_words[29]), 1'b1);
    chk("prbs next", 32'(prbs10(10'h3FD)), 32'(data_words[29]));
    chk("prbs live", 32'h0, 32'(data_words[29]), 1'b1);
    chk("prbs lanes", 32'(data_words[28]), 32'(data_words[29]), 1'b1);
    mark <= 5'h13;
    wait_word;
    chk("prbs slot", 32'(prbs10(prbs10(10'h3FD))), 32'(data_words[29]));
    chk("sync", 32'h2C5, 32'(sync_word));
    chk("rx count", 32'h0, 32'(rx_count), 1'b1);
    test_done();
  end
endmodule
